// *** hdl/cbtc_top.sv ***
// Behaviour
// - buffer output in 128-bit FIFO, then packetize
// - external data handled in 16-bit units
// - flow control between DMA fill and drain
// - frame-start and chirp-available events advance FSM
// - each chirp kicks DMA, drain fully
// - CSI-2 sequence; LVDS sends data only
// - interface select 0 CSI-2, 1 LVDS
// - FIFO error check enable bit
// - frame source 0 hardware, 1 software
// - chirp source 0 hardware, 1 software
// - write 1 makes software chirp trigger
// - write 1 makes software frame trigger
// - soft reset bit holds controller reset
// - walk entry list per chirp, each frame
`timescale 1ns/100ps
`default_nettype none

module cbtc_top #(
   parameter int FIFO_DEPTH = cbtc_pkg::FIFO_DEPTH
) (
   input  wire logic                              i_clk,
   input  wire logic                              i_reset,
   input  wire logic [cbtc_pkg::REG_ADDR_W-1:0]   i_reg_addr,
   input  wire logic [cbtc_pkg::REG_DATA_W-1:0]   i_reg_wdata,
   input  wire logic                              i_reg_wr,
   input  wire logic                              i_reg_rd,
   output logic      [cbtc_pkg::REG_DATA_W-1:0]   o_reg_rdata,
   input  wire logic                              i_hw_frame_start,
   input  wire logic                              i_hw_chirp_avail,
   output logic                                   o_dma_req,
   input  wire logic                              i_dma_wr_valid,
   input  wire logic [cbtc_pkg::FIFO_W-1:0]       i_dma_wr_data,
   output logic                                   o_dma_wr_ready,
   output logic                                   o_sync_valid,
   output logic      [2:0]                        o_sync_code,
   input  wire logic                              i_sync_ready,
   output logic                                   o_lane_valid,
   output logic      [cbtc_pkg::UNIT_W-1:0]       o_lane_data,
   input  wire logic                              i_lane_ready,
   output logic                                   o_interface_select
);
   import cbtc_pkg::*;

   localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
   localparam int IDX_W = $clog2(UNITS_PER_WORD);

   logic [CFG_STORE_W-1:0] cfg;
   logic [15:0]            chirps_per_frame;
   logic [5:0]             entries_per_chirp;
   logic [15:0]            units_per_entry;
   logic                   sw_chirp_pulse;
   logic                   sw_frame_pulse;
   logic                   ctrl_rst;
   logic                   frame_evt;
   logic                   chirp_evt;
   cbtc_state_t            st;
   logic [15:0]            chirp_cnt;
   logic [5:0]             entry_cnt;
   logic [15:0]            unit_left;
   logic [IDX_W-1:0]       unit_idx;
   logic                   sync_state;
   logic                   sync_done;
   logic [2:0]             next_sync_code;
   logic                   lane_free;
   logic                   lane_load;
   logic                   fifo_pop;
   logic                   fifo_valid;
   logic [FIFO_W-1:0]      fifo_head;
   logic [LVL_W-1:0]       fifo_level;
   logic                   fifo_ecc_err;
   logic                   ecc_err_seen;
   logic                   wr_cfg;
   logic                   last_entry;
   logic                   last_chirp;

   // picks one 16-bit unit out of a FIFO word
   function automatic logic [UNIT_W-1:0] word_unit(input logic [FIFO_W-1:0] w,
                                                   input logic [IDX_W-1:0]  idx);
      return w[idx*UNIT_W +: UNIT_W];
   endfunction : word_unit

   // controller reset is the chip reset or the software hold
   assign ctrl_rst  = i_reset | cfg[CFG_SRST_BIT];
   assign wr_cfg    = i_reg_wr & (i_reg_addr == REG_CONFIG);
   // trigger source muxes; hardware triggers ignored in software mode
   assign frame_evt = cfg[CFG_FSRC_BIT] ? sw_frame_pulse : i_hw_frame_start;
   assign chirp_evt = cfg[CFG_CSRC_BIT] ? sw_chirp_pulse : i_hw_chirp_avail;

   // configuration store, reset only by the chip reset so the hold survives
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cfg               <= CFG_RESET;
         chirps_per_frame  <= CHIRPS_RESET;
         entries_per_chirp <= ENTRIES_RESET;
         units_per_entry   <= UNITS_RESET;
      end
      else if (i_reg_wr)
      begin
         case (i_reg_addr)
            REG_CONFIG:  cfg <= {i_reg_wdata[CFG_SRST_BIT], 2'b00,
                                 i_reg_wdata[CFG_CSRC_BIT:CFG_IFSEL_BIT]};
            REG_CHIRPS:  chirps_per_frame  <= i_reg_wdata[15:0];
            REG_ENTRIES: entries_per_chirp <= i_reg_wdata[5:0];
            REG_UNITS:   units_per_entry   <= i_reg_wdata[15:0];
            default:     ;
         endcase
      end
   end

   // write-one pulses, never stored, so no write of zero is needed
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         sw_chirp_pulse <= 1'b0;
         sw_frame_pulse <= 1'b0;
      end
      else
      begin
         sw_chirp_pulse <= wr_cfg & i_reg_wdata[CFG_SWCHIRP_BIT];
         sw_frame_pulse <= wr_cfg & i_reg_wdata[CFG_SWFRAME_BIT];
      end
   end

   // read data stands the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_reg_rdata <= '0;
      else if (i_reg_rd)
      begin
         o_reg_rdata <= '0;
         case (i_reg_addr)
            REG_CONFIG:  o_reg_rdata[CFG_STORE_W-1:0] <= cfg;
            REG_CHIRPS:  o_reg_rdata[15:0] <= chirps_per_frame;
            REG_ENTRIES: o_reg_rdata[5:0]  <= entries_per_chirp;
            REG_UNITS:   o_reg_rdata[15:0] <= units_per_entry;
            REG_STATUS:
            begin
               o_reg_rdata[STA_STATE_LSB +: 4]     <= st;
               o_reg_rdata[STA_ECC_BIT]            <= ecc_err_seen;
               o_reg_rdata[STA_RESET_BIT]          <= ctrl_rst;
               o_reg_rdata[STA_LEVEL_LSB +: LVL_W] <= fifo_level;
               o_reg_rdata[STA_CHIRP_LSB +: 16]    <= chirp_cnt;
            end
            default:     o_reg_rdata <= '0;
         endcase
      end
      else
         o_reg_rdata <= '0;
   end

   // lane routing is only meaningful when fixed during the reset hold
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_interface_select <= 1'b0;
      else
         o_interface_select <= cfg[CFG_IFSEL_BIT];
   end

   // sticky error flag; cleared by the controller reset
   always_ff @(posedge i_clk)
   begin
      if (ctrl_rst)
         ecc_err_seen <= 1'b0;
      else if (fifo_ecc_err)
         ecc_err_seen <= 1'b1;
   end

   // sync steps finish at once in LVDS, after the engine's ready in CSI-2
   assign sync_state = (st == ST_FRAME_SYNC) || (st == ST_LINE_SYNC) ||
                       (st == ST_LONG_HDR) || (st == ST_LINE_END) || (st == ST_FRAME_END);
   assign sync_done  = sync_state & (cfg[CFG_IFSEL_BIT] | (o_sync_valid & i_sync_ready));
   assign last_entry = ({26'h0, entry_cnt} + 32'h1) >= {26'h0, entries_per_chirp};
   assign last_chirp = ({16'h0, chirp_cnt} + 32'h1) >= {16'h0, chirps_per_frame};

   always_comb
   begin
      case (st)
         ST_FRAME_SYNC: next_sync_code = SYNC_VS_START;
         ST_LINE_SYNC:  next_sync_code = SYNC_HS_START;
         ST_LONG_HDR:   next_sync_code = SYNC_LONG_HDR;
         ST_LINE_END:   next_sync_code = SYNC_HS_END;
         default:       next_sync_code = SYNC_VS_END;
      endcase
   end

   // sync packet request toward the protocol engine, CSI-2 only
   always_ff @(posedge i_clk)
   begin
      if (ctrl_rst)
      begin
         o_sync_valid <= 1'b0;
         o_sync_code  <= SYNC_VS_START;
      end
      else
      begin
         o_sync_valid <= sync_state & ~cfg[CFG_IFSEL_BIT] & ~sync_done;
         o_sync_code  <= next_sync_code;
      end
   end

   // controller sequence; held idle and deaf while in reset
   always_ff @(posedge i_clk)
   begin
      if (ctrl_rst)
      begin
         st        <= ST_IDLE;
         chirp_cnt <= '0;
         entry_cnt <= '0;
         o_dma_req <= 1'b0;
      end
      else
      begin
         o_dma_req <= 1'b0;
         case (st)
            ST_IDLE:       st <= ST_WAIT_FRAME;
            ST_WAIT_FRAME:
               if (frame_evt)
               begin
                  chirp_cnt <= '0;
                  st        <= ST_FRAME_SYNC;
               end
            ST_FRAME_SYNC:
               if (sync_done)
                  st <= ST_WAIT_CHIRP;
            ST_WAIT_CHIRP:
               if (chirp_evt)
               begin
                  o_dma_req <= 1'b1;
                  entry_cnt <= '0;
                  st        <= ST_LINE_SYNC;
               end
            ST_LINE_SYNC:
               if (sync_done)
                  st <= ST_LONG_HDR;
            ST_LONG_HDR:
               if (sync_done)
                  st <= ST_DATA;
            ST_DATA:
               if (unit_left == '0 && lane_free)
                  st <= ST_LINE_END;
            ST_LINE_END:
               if (sync_done)
               begin
                  if (!last_entry)
                  begin
                     entry_cnt <= entry_cnt + 6'h01;
                     st        <= ST_LINE_SYNC;
                  end
                  else if (!last_chirp)
                  begin
                     chirp_cnt <= chirp_cnt + 16'h0001;
                     st        <= ST_WAIT_CHIRP;
                  end
                  else
                     st <= ST_FRAME_END;
               end
            ST_FRAME_END:
               if (sync_done)
                  st <= ST_WAIT_FRAME;
            default:       st <= ST_IDLE;
         endcase
      end
   end

   // drain unit by unit; a partly used last word is dropped at entry end
   assign lane_free = ~o_lane_valid | i_lane_ready;
   assign lane_load = (st == ST_DATA) & (unit_left != '0) & fifo_valid & lane_free;
   assign fifo_pop  = lane_load &
                      ((unit_idx == IDX_W'(UNITS_PER_WORD - 1)) || (unit_left == 16'h0001));

   always_ff @(posedge i_clk)
   begin
      if (ctrl_rst)
      begin
         unit_left <= '0;
         unit_idx  <= '0;
      end
      else if (st == ST_LONG_HDR)
      begin
         unit_left <= units_per_entry;
         unit_idx  <= '0;
      end
      else if (lane_load)
      begin
         unit_left <= unit_left - 16'h0001;
         unit_idx  <= fifo_pop ? '0 : unit_idx + IDX_W'(1);
      end
   end

   // lane output register; held while the lanes stall
   always_ff @(posedge i_clk)
   begin
      if (ctrl_rst)
      begin
         o_lane_valid <= 1'b0;
         o_lane_data  <= '0;
      end
      else if (lane_free)
      begin
         o_lane_valid <= lane_load;
         if (lane_load)
            o_lane_data <= word_unit(fifo_head, unit_idx);
      end
   end

   cbtc_fifo #(
      .WIDTH  (FIFO_W),
      .DEPTH  (FIFO_DEPTH),
      .UNIT_W (UNIT_W),
      .LVL_W  (LVL_W)
   ) u_fifo (
      .i_clk      (i_clk),
      .i_reset    (ctrl_rst),
      .i_ecc_en   (cfg[CFG_ECC_BIT]),
      .i_wr_valid (i_dma_wr_valid),
      .i_wr_data  (i_dma_wr_data),
      .o_wr_ready (o_dma_wr_ready),
      .o_rd_valid (fifo_valid),
      .o_rd_data  (fifo_head),
      .i_rd_pop   (fifo_pop),
      .o_level    (fifo_level),
      .o_ecc_err  (fifo_ecc_err)
   );

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (ctrl_rst);

   sequence s_chirp_kick;
      (st == ST_WAIT_CHIRP) && chirp_evt;
   endsequence

   chk_chirp_kick: assert property (s_chirp_kick |=> o_dma_req && st == ST_LINE_SYNC)
      else $error("chirp event did not kick dma");

   chk_reset_holds_idle: assert property (disable iff (i_reset)
      cfg[CFG_SRST_BIT] |=> (st == ST_IDLE) && !o_dma_req && !o_lane_valid)
      else $error("controller active during soft reset");

   chk_lvds_no_sync: assert property (cfg[CFG_IFSEL_BIT] && $past(cfg[CFG_IFSEL_BIT])
      |-> !o_sync_valid)
      else $error("sync packet in lvds mode");

   chk_csi_frame_sync: assert property ($rose(st == ST_FRAME_SYNC) && !cfg[CFG_IFSEL_BIT]
      |=> o_sync_valid && o_sync_code == SYNC_VS_START)
      else $error("no frame start sync in csi mode");

   chk_sw_chirp_pulse: assert property (disable iff (i_reset) wr_cfg
      && i_reg_wdata[CFG_SWCHIRP_BIT] |=> sw_chirp_pulse ##1 (!sw_chirp_pulse || $past(wr_cfg)))
      else $error("software chirp write gave no single pulse");

   chk_sw_frame_pulse: assert property (disable iff (i_reset)
      wr_cfg && i_reg_wdata[CFG_SWFRAME_BIT] |=> sw_frame_pulse)
      else $error("software frame write gave no pulse");

   chk_hw_chirp_masked: assert property ((st == ST_WAIT_CHIRP) && cfg[CFG_CSRC_BIT]
      && !sw_chirp_pulse |=> !o_dma_req)
      else $error("hardware chirp acted in software mode");

   chk_frame_start_step: assert property ((st == ST_WAIT_FRAME) && frame_evt
      |=> st == ST_FRAME_SYNC)
      else $error("frame event did not start frame");

   chk_lane_hold_stall: assert property (o_lane_valid && !i_lane_ready
      |=> o_lane_valid && $stable(o_lane_data))
      else $error("lane data changed under stall");

   chk_chirp_loop: assert property ((st == ST_LINE_END) && sync_done && last_entry
      && !last_chirp |=> st == ST_WAIT_CHIRP && chirp_cnt == $past(chirp_cnt) + 16'h0001)
      else $error("chirp loop did not advance");

endmodule : cbtc_top

`default_nettype wire

// *** pkg/cbtc_pkg.sv ***
package cbtc_pkg;

   // register bus geometry
   localparam int                REG_ADDR_W      = 8;
   localparam int                REG_DATA_W      = 32;

   // register byte offsets
   localparam logic [7:0]        REG_CONFIG      = 8'h00;
   localparam logic [7:0]        REG_CHIRPS      = 8'h04;
   localparam logic [7:0]        REG_ENTRIES     = 8'h08;
   localparam logic [7:0]        REG_UNITS       = 8'h0C;
   localparam logic [7:0]        REG_STATUS      = 8'h10;

   // buffer_general_config field positions
   localparam int                CFG_IFSEL_BIT   = 0;
   localparam int                CFG_ECC_BIT     = 1;
   localparam int                CFG_FSRC_BIT    = 2;
   localparam int                CFG_CSRC_BIT    = 3;
   localparam int                CFG_SWCHIRP_BIT = 4;
   localparam int                CFG_SWFRAME_BIT = 5;
   localparam int                CFG_SRST_BIT    = 6;
   localparam int                CFG_STORE_W     = 7;

   // status field positions
   localparam int                STA_STATE_LSB   = 0;
   localparam int                STA_ECC_BIT     = 4;
   localparam int                STA_RESET_BIT   = 5;
   localparam int                STA_LEVEL_LSB   = 8;
   localparam int                STA_CHIRP_LSB   = 16;

   // reset values
   localparam logic [6:0]        CFG_RESET       = 7'h40;
   localparam logic [15:0]       CHIRPS_RESET    = 16'h0001;
   localparam logic [5:0]        ENTRIES_RESET   = 6'h01;
   localparam logic [15:0]       UNITS_RESET     = 16'h0008;

   // data path geometry
   localparam int                FIFO_W          = 128;
   localparam int                UNIT_W          = 16;
   localparam int                UNITS_PER_WORD  = FIFO_W / UNIT_W;
   localparam int                FIFO_DEPTH      = 8;
   localparam int                MAX_ENTRIES     = 32;

   // sync packet codes toward the protocol engine
   localparam logic [2:0]        SYNC_VS_START   = 3'h0;
   localparam logic [2:0]        SYNC_VS_END     = 3'h1;
   localparam logic [2:0]        SYNC_HS_START   = 3'h2;
   localparam logic [2:0]        SYNC_HS_END     = 3'h3;
   localparam logic [2:0]        SYNC_LONG_HDR   = 3'h4;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_WAIT_FRAME,
      ST_FRAME_SYNC,
      ST_WAIT_CHIRP,
      ST_LINE_SYNC,
      ST_LONG_HDR,
      ST_DATA,
      ST_LINE_END,
      ST_FRAME_END
   } cbtc_state_t;

endpackage : cbtc_pkg

// *** hdl/cbtc_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none

module cbtc_fifo #(
   parameter int WIDTH  = cbtc_pkg::FIFO_W,
   parameter int DEPTH  = cbtc_pkg::FIFO_DEPTH,
   parameter int UNIT_W = cbtc_pkg::UNIT_W,
   parameter int LVL_W  = $clog2(DEPTH + 1)
) (
   input  wire logic               i_clk,
   input  wire logic               i_reset,
   input  wire logic               i_ecc_en,
   input  wire logic               i_wr_valid,
   input  wire logic [WIDTH-1:0]   i_wr_data,
   output logic                    o_wr_ready,
   output logic                    o_rd_valid,
   output logic      [WIDTH-1:0]   o_rd_data,
   input  wire logic               i_rd_pop,
   output logic      [LVL_W-1:0]   o_level,
   output logic                    o_ecc_err
);
   import cbtc_pkg::*;

   localparam int NU    = WIDTH / UNIT_W;
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem    [DEPTH];
   logic [NU-1:0]    par    [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic             do_wr;
   logic             do_rd;
   logic [LVL_W-1:0] next_level;

   // one parity bit per 16-bit unit, computed on fill and on drain
   function automatic logic [NU-1:0] unit_parity(input logic [WIDTH-1:0] w);
      logic [NU-1:0] p;
      p = '0;
      for (int k = 0; k < NU; k++)
         p[k] = ^w[k*UNIT_W +: UNIT_W];
      return p;
   endfunction : unit_parity

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
   endfunction : ptr_inc

   // ready is a flop so the filling side sees back-pressure cleanly
   assign do_wr      = i_wr_valid & o_wr_ready;
   assign do_rd      = i_rd_pop & o_rd_valid;
   assign next_level = o_level + LVL_W'(do_wr) - LVL_W'(do_rd);
   assign o_rd_data  = mem[rd_ptr];

   // storage
   always_ff @(posedge i_clk)
   begin
      if (do_wr)
      begin
         mem[wr_ptr] <= i_wr_data;
         par[wr_ptr] <= unit_parity(i_wr_data);
      end
   end

   // pointers, level and flags
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         wr_ptr     <= '0;
         rd_ptr     <= '0;
         o_level    <= '0;
         o_wr_ready <= 1'b1;
         o_rd_valid <= 1'b0;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= ptr_inc(wr_ptr);
         if (do_rd)
            rd_ptr <= ptr_inc(rd_ptr);
         o_level    <= next_level;
         o_wr_ready <= (next_level != LVL_W'(DEPTH));
         o_rd_valid <= (next_level != '0);
      end
   end

   // check only when protection is switched on
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_ecc_err <= 1'b0;
      else
         o_ecc_err <= do_rd & i_ecc_en & (unit_parity(mem[rd_ptr]) != par[rd_ptr]);
   end

   chk_full_stalls_fill: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_level == LVL_W'(DEPTH)) |-> !o_wr_ready)
      else $error("fifo full but still ready");

endmodule : cbtc_fifo

`default_nettype wire

// *** tb/cbtc_lane_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// far side: protocol engine or lane transmitter, stalls at random
module cbtc_lane_model (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_lane_valid,
   input  wire logic i_sync_valid,
   output logic      o_lane_ready,
   output logic      o_sync_ready
);
   // random ready forces the design to hold valid and data under stall
   always_ff @(posedge i_clk)
   begin
      o_lane_ready <= !i_reset && (!i_lane_valid || $urandom_range(3) != 0);
      o_sync_ready <= !i_reset && (!i_sync_valid || $urandom_range(1) != 0);
   end
endmodule : cbtc_lane_model

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import cbtc_pkg::*;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
   logic         i_clk = 0, i_reset = 1, i_reg_wr = 0, i_reg_rd = 0;
   logic [7:0]   i_reg_addr = 8'h00;
   logic [31:0]  i_reg_wdata = 32'h0, o_reg_rdata;
   logic         i_hw_frame_start = 0, i_hw_chirp_avail = 0, i_dma_wr_valid = 0;
   logic [127:0] i_dma_wr_data = '0;
   logic         o_dma_req, o_dma_wr_ready, o_sync_valid, i_sync_ready;
   logic [2:0]   o_sync_code;
   logic         o_lane_valid, i_lane_ready, o_interface_select, rd_d;
   logic [15:0]  o_lane_data;
   int           fail_count = 0, compares = 0, dma_seen = 0;
   logic [31:0]  rd_q[$];
   logic [15:0]  lane_q[$];
   logic [2:0]   sync_q[$];

   always #12.5 i_clk = !i_clk;

   cbtc_top #(.FIFO_DEPTH(2)) u_cbtc_top (.i_clk(i_clk), .i_reset(i_reset),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_hw_frame_start(i_hw_frame_start),
      .i_hw_chirp_avail(i_hw_chirp_avail), .o_dma_req(o_dma_req),
      .i_dma_wr_valid(i_dma_wr_valid), .i_dma_wr_data(i_dma_wr_data),
      .o_dma_wr_ready(o_dma_wr_ready), .o_sync_valid(o_sync_valid),
      .o_sync_code(o_sync_code), .i_sync_ready(i_sync_ready), .o_lane_valid(o_lane_valid),
      .o_lane_data(o_lane_data), .i_lane_ready(i_lane_ready),
      .o_interface_select(o_interface_select));

   cbtc_lane_model u_cbtc_lane_model (.i_clk(i_clk), .i_reset(i_reset),
      .i_lane_valid(o_lane_valid), .i_sync_valid(o_sync_valid),
      .o_lane_ready(i_lane_ready), .o_sync_ready(i_sync_ready));

   // output watcher: oldest note against each result as it appears
   always @(posedge i_clk)
   begin
      rd_d <= i_reg_rd;
      if (rd_d) `CHK("rdata", rd_q.pop_front(), o_reg_rdata)
      if (o_lane_valid === 1'b1 && i_lane_ready)
         `CHK("lane", lane_q.pop_front(), o_lane_data)
      if (o_sync_valid === 1'b1 && i_sync_ready)
         `CHK("sync", sync_q.pop_front(), o_sync_code)
      if (o_dma_req === 1'b1) dma_seen++;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_reg_addr <= a; i_reg_wdata <= d; i_reg_wr <= 1; @(posedge i_clk);
      i_reg_wr <= 0; @(posedge i_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e); i_reg_addr <= a; i_reg_rd <= 1; @(posedge i_clk);
      i_reg_rd <= 0; @(posedge i_clk);
   endtask : rd

   task automatic pulse(input bit is_chirp);
      if (is_chirp) i_hw_chirp_avail <= 1; else i_hw_frame_start <= 1;
      @(posedge i_clk);
      if (is_chirp) i_hw_chirp_avail <= 0; else i_hw_frame_start <= 0;
   endtask : pulse

   // one chirp: wait for the kick, feed one word, expect its eight units
   task automatic chirp(input bit lvds, input bit fin);
      logic [127:0] w;
      int n;
      w = {$urandom, $urandom, $urandom, $urandom};
      if (!lvds) sync_q.push_back(SYNC_HS_START);
      if (!lvds) sync_q.push_back(SYNC_LONG_HDR);
      for (n = 0; n < 8; n++) lane_q.push_back(w[16*n +: 16]);
      if (!lvds) sync_q.push_back(SYNC_HS_END);
      if (!lvds && fin) sync_q.push_back(SYNC_VS_END);
      n = 0;
      while (o_dma_req !== 1'b1 && n < 50) begin @(posedge i_clk); n++; end
      if (n >= 50) fail_count++;
      i_dma_wr_valid <= 1; i_dma_wr_data <= w; @(posedge i_clk);
      while (o_dma_wr_ready !== 1'b1) @(posedge i_clk);
      i_dma_wr_valid <= 0;
      repeat (60) @(posedge i_clk);
   endtask : chirp

   task automatic end_of_test;
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      end_of_test();
   end

   initial
   begin
      void'($urandom(32'he4ad));
      repeat (2) @(posedge i_clk);
      i_reset <= 0; @(posedge i_clk);
      rd(REG_CONFIG, 32'h40);
      rd(REG_CHIRPS, 32'h1);
      rd(REG_ENTRIES, 32'h1);
      rd(REG_UNITS, 32'h8);
      rd(REG_STATUS, 32'h20);
      rd(8'h14, 32'h0);
      pulse(0); pulse(1);
      repeat (4) @(posedge i_clk);
      `CHK("dma in reset", 0, dma_seen)
      // lvds, hardware triggers; config written while held in reset
      wr(REG_CONFIG, 32'h41);
      wr(REG_CONFIG, 32'h01); repeat (3) @(posedge i_clk);
      `CHK("ifsel", 1'b1, o_interface_select)
      pulse(0); repeat (3) @(posedge i_clk);
      fork pulse(1); chirp(1, 1); join
      `CHK("lvds kicks", 1, dma_seen)
      // csi-2, software triggers at times of our choosing, parity on, two chirps
      wr(REG_CONFIG, 32'h4E); wr(REG_CHIRPS, 32'h2);
      wr(REG_CONFIG, 32'h0E);
      repeat (3) @(posedge i_clk);
      `CHK("ifsel", 1'b0, o_interface_select)
      pulse(1);
      sync_q.push_back(SYNC_VS_START);
      wr(REG_CONFIG, 32'h2E); repeat (20) @(posedge i_clk);
      pulse(1); repeat (3) @(posedge i_clk);
      `CHK("hw chirp ignored", 1, dma_seen)
      fork wr(REG_CONFIG, 32'h1E); chirp(0, 0); join
      rd(REG_STATUS, 32'h10003);
      fork wr(REG_CONFIG, 32'h1E); chirp(0, 1); join
      rd(REG_CONFIG, 32'h0E);
      rd(REG_STATUS, 32'h10001);
      repeat (3) @(posedge i_clk);
      `CHK("csi kicks", 3, dma_seen)
      `CHK("lanes left", 0, lane_q.size())
      `CHK("syncs left", 0, sync_q.size())
      end_of_test();
   end
endmodule : testbench

`default_nettype wire
